// >>> hw/hgsp_pkg.sv
// Shared constants and state types of the host read and serial port
package hgsp_pkg;
  // Clock rate and link timing
  localparam int CLK_MHZ      = 25;
  localparam int SCL_HALF_NS  = 320;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ) / 1000;
  localparam int RD_LOW_NS    = 480;
  localparam int RD_LOW_CYC   = (RD_LOW_NS * CLK_MHZ) / 1000;
  localparam int RD_HIGH_NS   = 160;
  localparam int RD_HIGH_CYC  = (RD_HIGH_NS * CLK_MHZ) / 1000;
  // Fixed upper identification bits; value is arbitrary
  localparam logic [4:0] ID_HI = 5'h0B;
  // Parallel mode strap codes
  localparam logic [3:0] M_16T1 = 4'h0;
  localparam logic [3:0] M_8T1  = 4'h1;
  localparam logic [3:0] M_16T2 = 4'h2;
  localparam logic [3:0] M_8T2  = 4'h3;
  localparam logic [3:0] M_18T1 = 4'h8;
  localparam logic [3:0] M_9T1  = 4'h9;
  localparam logic [3:0] M_18T2 = 4'hA;
  localparam logic [3:0] M_9T2  = 4'hB;
  // Middle strap pair for the serial ports
  localparam logic [1:0] SER_3W = 2'h2;
  localparam logic [1:0] SER_4W = 2'h3;
  // Pixel format register values
  localparam logic [7:0] FMT_565 = 8'h05;
  localparam logic [7:0] FMT_666 = 8'h06;
  // Device pin vector positions
  localparam int P_SEL   = 0;
  localparam int P_SCL   = 1;
  localparam int P_SDA   = 2;
  localparam int P_DCX   = 3;
  localparam int P_RD    = 4;
  localparam int P_STRAP = 5;
  // Host register map and command fields
  localparam logic [3:0] A_CMD  = 4'h0;
  localparam logic [3:0] A_STAT = 4'h4;
  localparam logic [3:0] A_RX   = 4'h8;
  localparam int CMD_BYTE_LSB = 8;
  localparam int CMD_DCX_BIT  = 16;
  localparam logic [1:0] OP_RELEASE = 2'h0;
  localparam logic [1:0] OP_SEND    = 2'h1;
  localparam logic [1:0] OP_RECV    = 2'h2;
  localparam logic [1:0] OP_PREAD   = 2'h3;
  // State machines
  typedef enum logic [2:0] {DS_IDLE, DS_START, DS_WR, DS_RD, DS_IGN}
    hgsp_dstate_t;
  typedef enum logic [2:0] {HS_IDLE, HS_SETUP, HS_LO, HS_HI, HS_RLO, HS_RHI}
    hgsp_hstate_t;
endpackage

// >>> hw/hgsp_link_if.sv
// Link pins between the host controller and the display device
`timescale 1ns/1ns
`default_nettype none
interface hgsp_link_if;
  logic        sel_n;
  logic        scl;
  logic        dcx;
  logic        rd_n;
  logic        sda_h;
  logic        sda_h_oe_n;
  logic        sda_d;
  logic        sda_d_oe_n;
  logic        sda_w;
  logic [17:0] db_d;
  logic        db_d_oe_n;
  logic [17:0] db_w;

  // Resolved wire levels; undriven lines float high
  assign sda_w = !sda_d_oe_n ? sda_d : (!sda_h_oe_n ? sda_h : 1'b1);
  assign db_w  = db_d_oe_n ? 18'h3FFFF : db_d;

  modport dev  (input sel_n, scl, dcx, rd_n, sda_w,
                output sda_d, sda_d_oe_n, db_d, db_d_oe_n);
  modport host (output sel_n, scl, dcx, rd_n, sda_h, sda_h_oe_n,
                input sda_w, db_w);
endinterface
`default_nettype wire

// >>> hw/hgsp_device.sv
// Display device end: pixel read formats and serial command port
// Notes on behaviour
// - 8-bit type one: dummy, R G B on 7:2
// - 16-bit type one: two pixels, three words
// - 9-bit type one: two low nine-bit reads
// - 18-bit type one: whole pixel per read
// - 8-bit type two: components on 17:12
// - 16-bit type two: fields 17:12, 8:3
// - 9-bit type two: two reads on 17:9
// - 18-bit type two: full pixel, red on top
// - Middle straps 10 three-wire, 11 four-wire
// - Serial works only while select low
// - Host sends start byte first in three-wire
// - Start byte: ID six, select, direction
// - ID fixed high, low bit from strap
// - Select bit: 0 index/status, 1 command/data
// - Direction bit: 0 write, 1 read
// - Reads give command data or status, never pixel memory
// - Four-wire bytes, command/data pin tags them
// - Bytes shift most significant bit first
// - Select high holds port idle, ignores pins
// - Select falling edge starts new transmission
// - Format 05: 16-bit 5-6-5 pixels
// - Format 06: 18-bit 6-6-6 pixels
`timescale 1ns/1ns
`default_nettype none
module hgsp_device (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  hgsp_link_if.dev         link_io,
  input  wire logic [3:0]  straps_i,
  input  wire logic [17:0] pix_i,
  output logic             pix_next_o,
  input  wire logic [7:0]  cmd_rd_i,
  input  wire logic [7:0]  status_i,
  input  wire logic [7:0]  pix_fmt_i,
  output logic [7:0]       rx_byte_o,
  output logic             rx_valid_o,
  output logic             rx_flag_o,
  output logic [17:0]      pix_wr_o,
  output logic             pix_wr_valid_o
);
  import hgsp_pkg::*;

  typedef struct packed {
    logic [8:0]   s1;
    logic [8:0]   s2;
    logic [8:0]   s3;
    logic [8:0]   lvl;
    hgsp_dstate_t st;
    logic [2:0]   bits;
    logic [7:0]   sh;
    logic [7:0]   tx;
    logic         rs;
    logic         sda;
    logic         sda_oe_n;
    logic [7:0]   rx;
    logic         rx_v;
    logic         rx_f;
    logic [1:0]   pc;
    logic [15:0]  pacc;
    logic [17:0]  pw;
    logic         pw_v;
    logic         dummy_done;
    logic [1:0]   ph;
    logic [17:0]  p0;
    logic [17:0]  p1;
    logic [17:0]  db;
    logic         db_oe_n;
    logic         nxt;
  } hgsp_dev_t;

  hgsp_dev_t   r_reg;
  hgsp_dev_t   r_next;
  logic [8:0]  pins;

  assign pins = {straps_i, link_io.rd_n, link_io.dcx, link_io.sda_w,
                 link_io.scl, link_io.sel_n};

  // Two six-bit fields in one sixteen-bit lane word
  function automatic logic [17:0] fmt16(input logic t2,
                                        input logic [5:0] x,
                                        input logic [5:0] y);
    fmt16 = t2 ? {x, 3'h0, y, 3'h0} : {2'h0, x, 2'h0, y, 2'h0};
  endfunction

  // Whole next-state function
  always_comb begin
    logic [8:0]  agree;
    logic        sel_fall;
    logic        scl_rise;
    logic        rd_fall;
    logic        three;
    logic        four;
    logic [3:0]  mode;
    logic [7:0]  byte_in;
    logic [7:0]  rd_src;
    logic [17:0] a;
    logic [17:0] b;
    logic [5:0]  c;
    logic [1:0]  last;
    r_next = r_reg;
    // Three-stage pin sampling; a level counts once stages two and three agree
    r_next.s1 = pins;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    agree = ~(r_reg.s2 ^ r_reg.s3);
    r_next.lvl = (agree & r_reg.s2) | (~agree & r_reg.lvl);
    sel_fall = r_reg.lvl[P_SEL] & ~r_next.lvl[P_SEL];
    scl_rise = ~r_reg.lvl[P_SCL] & r_next.lvl[P_SCL];
    rd_fall  = r_reg.lvl[P_RD] & ~r_next.lvl[P_RD];
    mode = r_reg.lvl[P_STRAP +: 4];
    three = (mode[2:1] == SER_3W);
    four  = (mode[2:1] == SER_4W);
    // incoming bit enters at the bottom
    byte_in = {r_reg.sh[6:0], r_reg.lvl[P_SDA]};
    // select bit picks command data or status
    rd_src = r_reg.rs ? cmd_rd_i : status_i;
    r_next.rx_v = 1'b0;
    r_next.pw_v = 1'b0;
    r_next.nxt  = 1'b0;
    a = 18'h00000;
    b = 18'h00000;
    c = 6'h00;
    last = 2'h0;

    if (r_reg.lvl[P_SEL]) begin
      r_next.st = DS_IDLE;
      r_next.sda_oe_n = 1'b1;
      r_next.dummy_done = 1'b0;
      r_next.ph = 2'h0;
    end

    if (sel_fall) begin
      r_next.st = three ? DS_START : (four ? DS_WR : DS_IGN);
      r_next.bits = 3'h0;
      r_next.pc = 2'h0;
    // clock edges act only with select low
    end else if (scl_rise && !r_reg.lvl[P_SEL]) begin
      r_next.bits = 3'(r_reg.bits + 3'h1);
      // data sampled on serial clock rise
      r_next.sh = byte_in;
      case (r_reg.st)
        DS_START: begin
          if (r_reg.bits == 3'h7) begin
            // first byte is the start byte
            r_next.st = DS_IGN;
            if (byte_in[7:2] == {ID_HI, mode[0]}) begin
              r_next.rs = byte_in[1];
              if (byte_in[0]) begin
                r_next.st = DS_RD;
                r_next.tx = byte_in[1] ? cmd_rd_i : status_i;
                r_next.sda = byte_in[1] ? cmd_rd_i[7] : status_i[7];
                r_next.sda_oe_n = 1'b0;
              end else begin
                r_next.st = DS_WR;
              end
            end
          end
        end
        DS_WR: begin
          if (r_reg.bits == 3'h7) begin
            r_next.rx = byte_in;
            r_next.rx_v = 1'b1;
            // tag from select bit or pin
            r_next.rx_f = three ? r_reg.rs : r_reg.lvl[P_DCX];
            if (four && !r_reg.lvl[P_DCX]) begin
              r_next.pc = 2'h0;
            end else if (four && pix_fmt_i == FMT_565) begin
              if (r_reg.pc == 2'h0) begin
                r_next.pacc[15:8] = byte_in;
                r_next.pc = 2'h1;
              end else begin
                r_next.pw = {r_reg.pacc[15:11], 1'b0, r_reg.pacc[10:8],
                             byte_in[7:5], byte_in[4:0], 1'b0};
                r_next.pw_v = 1'b1;
                r_next.pc = 2'h0;
              end
            end else if (four && pix_fmt_i == FMT_666) begin
              // three bytes, six bits each on top
              if (r_reg.pc == 2'h0) begin
                r_next.pacc[15:10] = byte_in[7:2];
                r_next.pc = 2'h1;
              end else if (r_reg.pc == 2'h1) begin
                r_next.pacc[9:4] = byte_in[7:2];
                r_next.pc = 2'h2;
              end else begin
                r_next.pw = {r_reg.pacc[15:4], byte_in[7:2]};
                r_next.pw_v = 1'b1;
                r_next.pc = 2'h0;
              end
            end
          end
        end
        DS_RD: begin
          // next bit is out before the next rise
          if (r_reg.bits == 3'h7) begin
            r_next.tx = rd_src;
            r_next.sda = rd_src[7];
          end else begin
            r_next.tx = {r_reg.tx[6:0], 1'b0};
            r_next.sda = r_reg.tx[6];
          end
        end
        default: begin
          r_next.st = r_reg.st;
        end
      endcase
    end

    // Parallel read: bus driven in parallel strap modes while selected and strobe low
    r_next.db_oe_n = mode[2] | r_reg.lvl[P_SEL] | r_reg.lvl[P_RD];
    if (rd_fall && !mode[2] && !r_next.lvl[P_SEL]) begin
      if (!r_reg.dummy_done) begin
        r_next.db = 18'h00000;
        r_next.dummy_done = 1'b1;
        r_next.ph = 2'h0;
      end else begin
        a = (r_reg.ph == 2'h0) ? pix_i : r_reg.p0;
        b = (r_reg.ph == 2'h1) ? pix_i : r_reg.p1;
        c = (r_reg.ph == 2'h0) ? a[17:12] :
            ((r_reg.ph == 2'h1) ? a[11:6] : a[5:0]);
        if (r_reg.ph == 2'h0) begin
          r_next.p0 = pix_i;
          r_next.nxt = 1'b1;
        end
        case ({mode[3], mode[0]})
          2'b01: begin
            r_next.db = mode[1] ? {c, 12'h000} : {10'h000, c, 2'h0};
            last = 2'h2;
          end
          2'b11: begin
            if (r_reg.ph == 2'h0) begin
              r_next.db = mode[1] ? {a[17:9], 9'h000} : {9'h000, a[17:9]};
            end else begin
              r_next.db = mode[1] ? {a[8:0], 9'h000} : {9'h000, a[8:0]};
            end
            last = 2'h1;
          end
          2'b10: begin
            r_next.db = a;
            last = 2'h0;
          end
          default: begin
            if (r_reg.ph == 2'h1) begin
              r_next.p1 = pix_i;
              r_next.nxt = 1'b1;
            end
            case (r_reg.ph)
              2'h0:    r_next.db = fmt16(mode[1], a[17:12], a[11:6]);
              2'h1:    r_next.db = fmt16(mode[1], a[5:0], b[17:12]);
              default: r_next.db = fmt16(mode[1], b[11:6], b[5:0]);
            endcase
            last = 2'h2;
          end
        endcase
        r_next.ph = (r_reg.ph == last) ? 2'h0 : 2'(r_reg.ph + 2'h1);
      end
    end
  end

  // State register; pins idle high so the sampler starts high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.s1 <= 9'h1FF;
      r_reg.s2 <= 9'h1FF;
      r_reg.s3 <= 9'h1FF;
      r_reg.lvl <= 9'h1FF;
      r_reg.st <= DS_IDLE;
      r_reg.sda <= 1'b1;
      r_reg.sda_oe_n <= 1'b1;
      r_reg.db_oe_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign link_io.sda_d      = r_reg.sda;
  assign link_io.sda_d_oe_n = r_reg.sda_oe_n;
  assign link_io.db_d       = r_reg.db;
  assign link_io.db_d_oe_n  = r_reg.db_oe_n;
  assign pix_next_o         = r_reg.nxt;
  assign rx_byte_o          = r_reg.rx;
  assign rx_valid_o         = r_reg.rx_v;
  assign rx_flag_o          = r_reg.rx_f;
  assign pix_wr_o           = r_reg.pw;
  assign pix_wr_valid_o     = r_reg.pw_v;
endmodule
`default_nettype wire

// >>> hw/hgsp_host.sv
// Host controller end: Wishbone command registers driving the link
`timescale 1ns/1ns
`default_nettype none
module hgsp_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  hgsp_link_if.host        link_io
);
  import hgsp_pkg::*;

  typedef struct packed {
    logic [18:0]  s1;
    logic [18:0]  s2;
    logic [18:0]  s3;
    logic [18:0]  lvl;
    hgsp_hstate_t st;
    logic [3:0]   cnt;
    logic [2:0]   bitn;
    logic [7:0]   sh;
    logic [17:0]  rx;
    logic [1:0]   op;
    logic         sel_n;
    logic         scl;
    logic         sda;
    logic         sda_oe_n;
    logic         dcx;
    logic         rd_n;
    logic         ack;
    logic [31:0]  dat;
  } hgsp_host_t;

  hgsp_host_t r_reg;
  hgsp_host_t r_next;

  // Whole next-state function
  always_comb begin
    logic [18:0] agree;
    logic        req;
    logic        done;
    r_next = r_reg;
    // Device-driven lines pass three stages before use
    r_next.s1 = {link_io.db_w, link_io.sda_w};
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    agree = ~(r_reg.s2 ^ r_reg.s3);
    r_next.lvl = (agree & r_reg.s2) | (~agree & r_reg.lvl);
    req = wb_cyc_i & wb_stb_i & ~r_reg.ack;
    r_next.cnt = 4'(r_reg.cnt + 4'h1);
    done = 1'b0;

    // Classic single-cycle slave: answer one cycle after the request
    r_next.ack = req;
    r_next.dat = 32'h00000000;
    if (req && !wb_we_i && wb_adr_i == A_STAT) begin
      r_next.dat = {31'h00000000, r_reg.st != HS_IDLE};
    end else if (req && !wb_we_i && wb_adr_i == A_RX) begin
      r_next.dat = {14'h0000, r_reg.rx};
    end

    case (r_reg.st)
      HS_IDLE: begin
        // Commands while busy are dropped, so poll status first
        if (req && wb_we_i && wb_adr_i == A_CMD && wb_sel_i[0]) begin
          r_next.op = wb_dat_i[1:0];
          r_next.sh = wb_dat_i[CMD_BYTE_LSB +: 8];
          r_next.dcx = wb_dat_i[CMD_DCX_BIT];
          r_next.cnt = 4'h0;
          r_next.bitn = 3'h0;
          if (wb_dat_i[1:0] == OP_RELEASE) begin
            // select high resets the far port
            r_next.sel_n = 1'b1;
            r_next.sda_oe_n = 1'b1;
          end else begin
            r_next.sel_n = 1'b0;
            // release the line when reading back
            r_next.sda_oe_n = (wb_dat_i[1:0] != OP_SEND);
            r_next.sda = wb_dat_i[CMD_BYTE_LSB + 7];
            if (r_reg.sel_n) begin
              r_next.st = HS_SETUP;
            end else if (wb_dat_i[1:0] == OP_PREAD) begin
              r_next.st = HS_RLO;
              r_next.rd_n = 1'b0;
            end else begin
              r_next.st = HS_LO;
              r_next.scl = 1'b0;
            end
          end
        end
      end
      HS_SETUP: begin
        if (r_reg.cnt == 4'(SCL_HALF_CYC - 1)) begin
          r_next.cnt = 4'h0;
          r_next.st = (r_reg.op == OP_PREAD) ? HS_RLO : HS_LO;
          r_next.rd_n = (r_reg.op != OP_PREAD);
          r_next.scl = (r_reg.op == OP_PREAD);
        end
      end
      HS_LO: begin
        if (r_reg.cnt == 4'(SCL_HALF_CYC - 1)) begin
          // rise: device samples, host takes read bit
          r_next.cnt = 4'h0;
          r_next.scl = 1'b1;
          r_next.st = HS_HI;
          r_next.rx = {r_reg.rx[16:0], r_reg.lvl[0]};
        end
      end
      HS_HI: begin
        if (r_reg.cnt == 4'(SCL_HALF_CYC - 1)) begin
          r_next.cnt = 4'h0;
          r_next.bitn = 3'(r_reg.bitn + 3'h1);
          r_next.sh = {r_reg.sh[6:0], 1'b0};
          r_next.sda = r_reg.sh[6];
          done = (r_reg.bitn == 3'h7);
          r_next.st = done ? HS_IDLE : HS_LO;
          r_next.scl = done;
        end
      end
      HS_RLO: begin
        if (r_reg.cnt == 4'(RD_LOW_CYC - 1)) begin
          // Word taken just before the strobe rises
          r_next.cnt = 4'h0;
          r_next.rx = r_reg.lvl[18:1];
          r_next.rd_n = 1'b1;
          r_next.st = HS_RHI;
        end
      end
      HS_RHI: begin
        if (r_reg.cnt == 4'(RD_HIGH_CYC - 1)) begin
          r_next.st = HS_IDLE;
        end
      end
      default: begin
        r_next.st = HS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.s1 <= 19'h7FFFF;
      r_reg.s2 <= 19'h7FFFF;
      r_reg.s3 <= 19'h7FFFF;
      r_reg.lvl <= 19'h7FFFF;
      r_reg.st <= HS_IDLE;
      r_reg.sel_n <= 1'b1;
      r_reg.scl <= 1'b1;
      r_reg.sda <= 1'b1;
      r_reg.sda_oe_n <= 1'b1;
      r_reg.rd_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o           = r_reg.dat;
  assign wb_ack_o           = r_reg.ack;
  assign link_io.sel_n      = r_reg.sel_n;
  assign link_io.scl        = r_reg.scl;
  assign link_io.dcx        = r_reg.dcx;
  assign link_io.rd_n       = r_reg.rd_n;
  assign link_io.sda_h      = r_reg.sda;
  assign link_io.sda_h_oe_n = r_reg.sda_oe_n;
endmodule
`default_nettype wire

// >>> bench/hgsp_checker.sv
// Link timing assertions for the host read and serial port
`timescale 1ns/1ns
`default_nettype none
module hgsp_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sel_n,
  input wire logic scl,
  input wire logic rd_n,
  input wire logic sda_h,
  input wire logic sda_d,
  input wire logic sda_d_oe_n,
  input wire logic db_d_oe_n
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Clock parks high whenever the select is up
  property p_scl_idle; sel_n |-> scl; endproperty
  a_scl_idle: assert property (p_scl_idle)
    else $error("serial clock low while deselected");
  // A deselected device lets go of both data paths
  property p_dev_quiet; sel_n [*8] |-> sda_d_oe_n && db_d_oe_n; endproperty
  a_dev_quiet: assert property (p_dev_quiet)
    else $error("device drives while deselected");
  // Host bit stays put for six clocks after the rise
  property p_bit_hold; (!sel_n && $rose(scl)) |=> $stable(sda_h) [*6];
  endproperty
  a_bit_hold: assert property (p_bit_hold)
    else $error("host data moved while clock high");
  // Read data only changes after a rising edge, never across a fall
  property p_dev_steady; (!sda_d_oe_n && $fell(scl)) |-> $stable(sda_d) [*8];
  endproperty
  a_dev_steady: assert property (p_dev_steady)
    else $error("device data moved around the clock fall");
  // Parallel bus is released shortly after the read strobe ends
  property p_rd_release; rd_n [*7] |-> db_d_oe_n; endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("parallel bus held after read strobe");
  // Reads happen only inside a selected frame
  property p_rd_frame; $fell(rd_n) |-> !sel_n; endproperty
  a_rd_frame: assert property (p_rd_frame)
    else $error("read strobe outside select");
  // A new frame starts with the clock idle and the bus free
  property p_sel_start; $fell(sel_n) |-> scl && db_d_oe_n; endproperty
  a_sel_start: assert property (p_sel_start)
    else $error("frame start with clock low or bus driven");
  // Low half lasts eight clocks, then the clock rises
  property p_scl_low; $fell(scl) |-> (!scl) [*8] ##1 scl; endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("serial clock low half wrong length");
  // High half lasts at least eight clocks
  property p_scl_high; (!sel_n && $rose(scl)) |-> scl [*8]; endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("serial clock high half too short");
endmodule
`default_nettype wire

// >>> bench/tb_host_gram_read_and_serial_port.sv
// Self-checking bench joining host and device ends over the link
`timescale 1ns/1ns
`default_nettype none
module tb_host_gram_read_and_serial_port;
  import hgsp_pkg::*;
  logic        clk_i, rst_i, wb_we, wb_cyc, wb_stb, wb_ack;
  logic [3:0]  wb_adr, wb_sel, straps;
  logic [31:0] wb_wdat, wb_rdat, q;
  logic [7:0]  cmd_rd, status, pix_fmt, rx_byte, rx_last;
  logic        pix_next, rx_valid, rx_flag, pix_wr_valid, flag_last;
  logic [17:0] pix_in, pix_wr, pix_last;
  logic [3:0]  md [8];
  int          err_total = 0, checks = 0, cyc_cnt = 0, idx = 0, base;

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

  hgsp_link_if u_hgsp_link_if ();
  hgsp_host u_hgsp_host (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr),
    .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel), .wb_we_i(wb_we),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .link_io(u_hgsp_link_if));
  hgsp_device u_hgsp_device (.clk_i(clk_i), .rst_i(rst_i),
    .link_io(u_hgsp_link_if), .straps_i(straps), .pix_i(pix_in),
    .pix_next_o(pix_next), .cmd_rd_i(cmd_rd), .status_i(status),
    .pix_fmt_i(pix_fmt), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
    .rx_flag_o(rx_flag), .pix_wr_o(pix_wr), .pix_wr_valid_o(pix_wr_valid));
  hgsp_checker u_hgsp_checker (.clk_i(clk_i), .rst_i(rst_i),
    .sel_n(u_hgsp_link_if.sel_n), .scl(u_hgsp_link_if.scl),
    .rd_n(u_hgsp_link_if.rd_n), .sda_h(u_hgsp_link_if.sda_h),
    .sda_d(u_hgsp_link_if.sda_d), .sda_d_oe_n(u_hgsp_link_if.sda_d_oe_n),
    .db_d_oe_n(u_hgsp_link_if.db_d_oe_n));

  // Stored pixel table with distinct colour fields
  function automatic logic [17:0] tab(input int i);
    return {6'(i * 5 + 3), 6'(i * 11 + 17), 6'(i * 3 + 40)};
  endfunction
  // Colour component n of the stream, red first
  function automatic logic [17:0] comp(input int b, input int n);
    logic [17:0] p;
    p = tab(b + n / 3);
    return (n % 3 == 0) ? p[17:12] : (n % 3 == 1) ? p[11:6] : p[5:0];
  endfunction
  // Expected read word k after the dummy, per lane format
  function automatic logic [17:0] expw(input logic [3:0] m, input int b,
                                       input int k);
    logic [17:0] p;
    p = tab(b + k / 2);
    case (m)
      M_8T1:   return comp(b, k) << 2;
      M_8T2:   return comp(b, k) << 12;
      M_16T1:  return (comp(b, 2 * k) << 10) | (comp(b, 2 * k + 1) << 2);
      M_16T2:  return (comp(b, 2 * k) << 12) | (comp(b, 2 * k + 1) << 3);
      M_9T1:   return (k % 2) ? 18'(p[8:0]) : 18'(p[17:9]);
      M_9T2:   return (k % 2) ? {p[8:0], 9'h000} : {p[17:9], 9'h000};
      default: return tab(b + k);
    endcase
  endfunction
  // Lanes that carry data; the rest are free for the device
  function automatic logic [17:0] msk(input logic [3:0] m);
    case (m)
      M_8T1:   return 18'h000FC;
      M_8T2:   return 18'h3F000;
      M_16T1:  return 18'h0FCFC;
      M_16T2:  return 18'h3F1F8;
      M_9T1:   return 18'h001FF;
      M_9T2:   return 18'h3FE00;
      default: return 18'h3FFFF;
    endcase
  endfunction
  // Start byte: identity, register select, direction
  function automatic logic [7:0] sb(input logic rs, rw, id0);
    return {ID_HI, id0, rs, rw};
  endfunction

  // Classic single Wishbone cycle, held until ack is seen
  task automatic wb(input logic [3:0] a, input logic w,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    wb_adr <= a;
    wb_we <= w;
    wb_wdat <= d;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // Issue one link command and poll until the host is idle again
  task automatic op(input logic [1:0] o, input logic [7:0] b, input logic d);
    logic [31:0] r;
    wb(A_CMD, 1'b1, {15'h0000, d, b, 6'h00, o}, r);
    r = 32'h1;
    // Ends once status bit 0 reads idle; the hang guard ends a stuck wait
    while (r[0] !== 1'b0) wb(A_STAT, 1'b0, 0, r);
  endtask
  // Straps pass a slow sampler, so let them settle while idle
  task automatic set_mode(input logic [3:0] m);
    @(posedge clk_i);
    straps <= m;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic complete_run;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  assign pix_in = tab(idx);
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Receive monitor, pixel stepping and hang guard
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (rx_valid === 1'b1) begin
      rx_last <= rx_byte;
      flag_last <= rx_flag;
    end
    if (pix_wr_valid === 1'b1) pix_last <= pix_wr;
    if (pix_next === 1'b1) idx <= idx + 1;
    // Guard comes last so nothing runs after the run ends
    if (cyc_cnt > 40000) begin
      err_total++;
      complete_run;
    end
  end

  initial begin
    {wb_we, wb_cyc, wb_stb, wb_adr, wb_wdat} = '0;
    wb_sel = 4'hF;
    {straps, pix_fmt, cmd_rd, status} = {4'h6, FMT_565, 8'hC3, 8'h5E};
    md = '{M_8T1, M_16T1, M_9T1, M_18T1, M_8T2, M_16T2, M_9T2, M_18T2};
    rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(4'hC, 1'b0, 0, q);
    `CHK(q, 32'h0)
    // Four-wire command byte, then two 5-6-5 data bytes
    op(OP_SEND, 8'hA5, 1'b0);
    `CHK({flag_last, rx_last}, 9'h0A5)
    op(OP_SEND, 8'hAD, 1'b1);
    op(OP_SEND, 8'h4C, 1'b1);
    `CHK({flag_last, rx_last}, 9'h14C)
    `CHK(pix_last, {5'h15, 1'b0, 6'h2A, 5'h0C, 1'b0})
    op(OP_SEND, 8'h00, 1'b0);
    pix_fmt <= FMT_666;
    op(OP_SEND, 8'hAC, 1'b1);
    op(OP_SEND, 8'h44, 1'b1);
    op(OP_SEND, 8'hF8, 1'b1);
    `CHK(pix_last, {6'h2B, 6'h11, 6'h3E})
    op(OP_RELEASE, 8'h00, 1'b0);
    // Three-wire frames: data write, index write, bad identity
    set_mode(4'h5);
    op(OP_SEND, sb(1'b1, 1'b0, 1'b1), 1'b0);
    op(OP_SEND, 8'h3C, 1'b0);
    `CHK({flag_last, rx_last}, 9'h13C)
    op(OP_RELEASE, 8'h00, 1'b0);
    op(OP_SEND, sb(1'b0, 1'b0, 1'b1), 1'b0);
    op(OP_SEND, 8'h61, 1'b0);
    `CHK({flag_last, rx_last}, 9'h061)
    op(OP_RELEASE, 8'h00, 1'b0);
    op(OP_SEND, sb(1'b1, 1'b0, 1'b0), 1'b0);
    op(OP_SEND, 8'h5A, 1'b0);
    `CHK({flag_last, rx_last}, 9'h061)
    op(OP_RELEASE, 8'h00, 1'b0);
    // Three-wire reads give the command byte or the status byte
    op(OP_SEND, sb(1'b1, 1'b1, 1'b1), 1'b0);
    op(OP_RECV, 8'h00, 1'b0);
    wb(A_RX, 1'b0, 0, q);
    `CHK(q[7:0], 8'hC3)
    op(OP_RELEASE, 8'h00, 1'b0);
    op(OP_SEND, sb(1'b0, 1'b1, 1'b1), 1'b0);
    op(OP_RECV, 8'h00, 1'b0);
    wb(A_RX, 1'b0, 0, q);
    `CHK(q[7:0], 8'h5E)
    op(OP_RELEASE, 8'h00, 1'b0);
    // Serial straps refuse parallel reads, bus floats high
    op(OP_PREAD, 8'h00, 1'b0);
    wb(A_RX, 1'b0, 0, q);
    `CHK(q[17:0], 18'h3FFFF)
    op(OP_RELEASE, 8'h00, 1'b0);
    // Every parallel lane format: dummy read, then six words
    for (int m = 0; m < 8; m++) begin
      set_mode(md[m]);
      base = idx;
      op(OP_PREAD, 8'h00, 1'b0);
      for (int k = 0; k < 6; k++) begin
        op(OP_PREAD, 8'h00, 1'b0);
        wb(A_RX, 1'b0, 0, q);
        `CHK(q[17:0] & msk(md[m]), expw(md[m], base, k))
      end
      op(OP_RELEASE, 8'h00, 1'b0);
    end
    complete_run;
  end
`undef CHK
endmodule
`default_nettype wire
